// [pkg/reader_status_pkg.sv]
// constants for the reader status and event register group
package reader_status_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 6;
    localparam int CLASH_BYTE_W = 4;
    localparam int CLASH_BIT_W = 3;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 6'h07;
    localparam logic [ADDR_W-1:0] EVENT_FLAGS_ADDR = 6'h08;
    localparam logic [ADDR_W-1:0] FIFO_FILL_STATUS_ADDR = 6'h09;
    localparam logic [ADDR_W-1:0] COLLISION_POSITION_ADDR = 6'h0a;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] EVENT_MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] EVENT_FLAGS_RST = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
    localparam logic [COUNT_W-1:0] UNREAD_COUNT_RST = 6'h00;
    localparam logic [CLASH_BYTE_W-1:0] CLASH_BYTE_RST = 4'h0;
    localparam logic [CLASH_BIT_W-1:0] CLASH_BIT_RST = 3'h0;
    // ------------------------------------------------------------------
    // event flag bit positions
    // ------------------------------------------------------------------
    localparam int OSC_STABLE_BIT = 7;
    localparam int NFC_EVENT_BIT = 6;
    localparam int WATER_LEVEL_BIT = 5;
    localparam int RX_END_BIT = 4;
    localparam int TX_END_BIT = 3;
    localparam int CODING_ERR_BIT = 2;
    localparam int CRC_ERR_BIT = 1;
    localparam int BIT_COLLISION_BIT = 0;
    // ------------------------------------------------------------------
    // fifo status and collision field positions
    // ------------------------------------------------------------------
    localparam int UNREAD_COUNT_LSB = 2;
    localparam int OVERFLOW_BIT = 1;
    localparam int RX_ACTIVE_BIT = 0;
    localparam int CLASH_BYTE_LSB = 4;
    localparam int CLASH_BIT_LSB = 1;
    localparam logic [COUNT_W-1:0] UNREAD_COUNT_MAX = 6'h20;
endpackage

// [hw/reader_irq_fifo_status_regs.sv]
// status, event and collision registers of the reader framing engine
`timescale 1ns/100ps
`default_nettype none
module reader_irq_fifo_status_regs #(
    parameter int COUNT_W = reader_status_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [reader_status_pkg::ADDR_W-1:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [reader_status_pkg::DATA_W-1:0] regWrData,
    output logic [reader_status_pkg::DATA_W-1:0] regRdData,
    input wire logic setDefaultCmd,
    input wire logic clearCmd,
    input wire logic oscEnable,
    input wire logic oscStable,
    input wire logic nfcTargetDetect,
    input wire logic extFieldDetect,
    input wire logic caFieldAbort,
    input wire logic fifoAlmostFull,
    input wire logic fifoAlmostEmpty,
    input wire logic txBusy,
    input wire logic rxEndEvt,
    input wire logic txEndEvt,
    input wire logic codingErrEvt,
    input wire logic crcErrEvt,
    input wire logic bitCollisionEvt,
    input wire logic isoAMode,
    input wire logic [reader_status_pkg::CLASH_BYTE_W-1:0] clashByteCount,
    input wire logic [reader_status_pkg::CLASH_BIT_W-1:0] clashBitCount,
    input wire logic [COUNT_W-1:0] fifoUnread,
    input wire logic fifoPushWhenFull,
    input wire logic tagMsgStart,
    input wire logic tagMsgEnd,
    output logic irqOutPin
);
    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic rdFlags;
    logic wrMask;
    logic clearAll;
    logic [reader_status_pkg::DATA_W-1:0] eventSet;
    logic [reader_status_pkg::DATA_W-1:0] eventFlags_reg;
    logic [reader_status_pkg::DATA_W-1:0] eventFlags_next;
    logic [reader_status_pkg::DATA_W-1:0] waterLevelMask_reg;
    logic [COUNT_W-1:0] unreadCount_reg;
    logic overflow_reg;
    logic rxActive_reg;
    logic [reader_status_pkg::CLASH_BYTE_W-1:0] clashBytes_reg;
    logic [reader_status_pkg::CLASH_BIT_W-1:0] clashBits_reg;
    logic oscStableDly_reg;
    logic fieldDly_reg;
    logic [reader_status_pkg::DATA_W-1:0] fifoStatusView;
    logic [reader_status_pkg::DATA_W-1:0] collisionView;

    // access strobes
    assign rdFlags = regRdEn && (regAddr == reader_status_pkg::EVENT_FLAGS_ADDR);
    assign wrMask = regWrEn && (regAddr == reader_status_pkg::EVENT_MASK_ADDR);
    assign clearAll = setDefaultCmd || clearCmd;

    // ------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------
    // edge detectors for level sources
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscStableDly_reg <= 1'b0;
            fieldDly_reg <= 1'b0;
        end else begin
            oscStableDly_reg <= oscStable;
            fieldDly_reg <= extFieldDetect;
        end
    end

    // one-cycle set requests per flag
    always_comb begin
        eventSet = reader_status_pkg::EVENT_FLAGS_RST;
        eventSet[reader_status_pkg::OSC_STABLE_BIT] =
            oscEnable && oscStable && !oscStableDly_reg;
        eventSet[reader_status_pkg::NFC_EVENT_BIT] =
            (nfcTargetDetect && !oscEnable && extFieldDetect && !fieldDly_reg)
            || caFieldAbort;
        eventSet[reader_status_pkg::WATER_LEVEL_BIT] =
            (fifoAlmostFull && rxActive_reg)
            || (fifoAlmostEmpty && txBusy);
        eventSet[reader_status_pkg::RX_END_BIT] = rxEndEvt;
        eventSet[reader_status_pkg::TX_END_BIT] = txEndEvt;
        eventSet[reader_status_pkg::CODING_ERR_BIT] = codingErrEvt;
        eventSet[reader_status_pkg::CRC_ERR_BIT] = crcErrEvt;
        eventSet[reader_status_pkg::BIT_COLLISION_BIT] = bitCollisionEvt && isoAMode;
    end

    // ------------------------------------------------------------------
    // event flags, clear on read
    // ------------------------------------------------------------------
    // read clears, but a set in the same cycle survives
    always_comb begin
        if (setDefaultCmd || rdFlags) begin
            eventFlags_next = eventSet;
        end else begin
            eventFlags_next = eventFlags_reg | eventSet;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eventFlags_reg <= reader_status_pkg::EVENT_FLAGS_RST;
        end else begin
            eventFlags_reg <= eventFlags_next;
        end
    end

    // mask register, written by host
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waterLevelMask_reg <= reader_status_pkg::EVENT_MASK_RST;
        end else if (setDefaultCmd) begin
            waterLevelMask_reg <= reader_status_pkg::EVENT_MASK_RST;
        end else if (wrMask) begin
            waterLevelMask_reg <= regWrData;
        end
    end

    // interrupt from unmasked flags
    assign irqOutPin = |(eventFlags_reg & ~waterLevelMask_reg);

    // ------------------------------------------------------------------
    // fifo status
    // ------------------------------------------------------------------
    // mirror of the unread byte count, saturated at UNREAD_COUNT_MAX
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unreadCount_reg <= reader_status_pkg::UNREAD_COUNT_RST;
        end else if (clearAll) begin
            unreadCount_reg <= reader_status_pkg::UNREAD_COUNT_RST;
        end else if (fifoUnread > reader_status_pkg::UNREAD_COUNT_MAX) begin
            unreadCount_reg <= reader_status_pkg::UNREAD_COUNT_MAX;
        end else begin
            unreadCount_reg <= fifoUnread;
        end
    end

    // sticky overflow, set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overflow_reg <= 1'b0;
        end else if (fifoPushWhenFull) begin
            overflow_reg <= 1'b1;
        end else if (clearAll) begin
            overflow_reg <= 1'b0;
        end
    end

    // reception active between message start and end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxActive_reg <= 1'b0;
        end else if (tagMsgStart) begin
            rxActive_reg <= 1'b1;
        end else if (tagMsgEnd || clearAll) begin
            rxActive_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // collision position
    // ------------------------------------------------------------------
    // capture position of an iso a collision
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clashBytes_reg <= reader_status_pkg::CLASH_BYTE_RST;
            clashBits_reg <= reader_status_pkg::CLASH_BIT_RST;
        end else if (bitCollisionEvt && isoAMode) begin
            clashBytes_reg <= clashByteCount;
            clashBits_reg <= clashBitCount;
        end else if (clearAll) begin
            clashBytes_reg <= reader_status_pkg::CLASH_BYTE_RST;
            clashBits_reg <= reader_status_pkg::CLASH_BIT_RST;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // assemble read views
    always_comb begin
        fifoStatusView = reader_status_pkg::READ_IDLE;
        fifoStatusView[reader_status_pkg::UNREAD_COUNT_LSB +: COUNT_W] = unreadCount_reg;
        fifoStatusView[reader_status_pkg::OVERFLOW_BIT] = overflow_reg;
        fifoStatusView[reader_status_pkg::RX_ACTIVE_BIT] = rxActive_reg;
        collisionView = reader_status_pkg::READ_IDLE; // unused bit reads zero
        collisionView[reader_status_pkg::CLASH_BYTE_LSB +: reader_status_pkg::CLASH_BYTE_W] =
            clashBytes_reg;
        collisionView[reader_status_pkg::CLASH_BIT_LSB +: reader_status_pkg::CLASH_BIT_W] =
            clashBits_reg;
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= reader_status_pkg::READ_IDLE;
        end else if (regRdEn) begin
            unique case (regAddr)
                reader_status_pkg::EVENT_MASK_ADDR: regRdData <= waterLevelMask_reg;
                reader_status_pkg::EVENT_FLAGS_ADDR: regRdData <= eventFlags_reg;
                reader_status_pkg::FIFO_FILL_STATUS_ADDR: regRdData <= fifoStatusView;
                reader_status_pkg::COLLISION_POSITION_ADDR: regRdData <= collisionView;
                default: regRdData <= reader_status_pkg::READ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_osc;
        $rose(oscStable) && oscEnable |=> eventFlags_reg[reader_status_pkg::OSC_STABLE_BIT];
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator flag missed");

    property p_field;
        $rose(extFieldDetect) && nfcTargetDetect && !oscEnable
            |=> eventFlags_reg[reader_status_pkg::NFC_EVENT_BIT];
    endproperty
    a_field: assert property (p_field) else $error("field flag missed");

    property p_ca;
        caFieldAbort |=> eventFlags_reg[reader_status_pkg::NFC_EVENT_BIT];
    endproperty
    a_ca: assert property (p_ca) else $error("abort flag missed");

    property p_wl;
        (fifoAlmostFull && rxActive_reg) || (fifoAlmostEmpty && txBusy)
            |=> eventFlags_reg[reader_status_pkg::WATER_LEVEL_BIT];
    endproperty
    a_wl: assert property (p_wl) else $error("water level flag missed");

    property p_ends;
        (rxEndEvt |=> eventFlags_reg[reader_status_pkg::RX_END_BIT])
            and (txEndEvt |=> eventFlags_reg[reader_status_pkg::TX_END_BIT]);
    endproperty
    a_ends: assert property (p_ends) else $error("end flags missed");

    property p_errs;
        (codingErrEvt |=> eventFlags_reg[reader_status_pkg::CODING_ERR_BIT])
            and (crcErrEvt |=> eventFlags_reg[reader_status_pkg::CRC_ERR_BIT]);
    endproperty
    a_errs: assert property (p_errs) else $error("error flags missed");

    property p_col;
        bitCollisionEvt && isoAMode |=> eventFlags_reg[reader_status_pkg::BIT_COLLISION_BIT]
            && collisionView[reader_status_pkg::CLASH_BYTE_LSB +: reader_status_pkg::CLASH_BYTE_W]
            == $past(clashByteCount) && collisionView[0] == 1'b0;
    endproperty
    a_col: assert property (p_col) else $error("collision capture wrong");

    property p_rdclr;
        rdFlags && eventSet == reader_status_pkg::EVENT_FLAGS_RST
            |=> regRdData == $past(eventFlags_reg) && eventFlags_reg == 8'h00 && !irqOutPin;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear flags");

    property p_irq;
        ($rose(irqOutPin) |-> $past(eventSet) != 8'h00 || $past(wrMask))
            and ($fell(irqOutPin) |-> $past(rdFlags) || $past(setDefaultCmd) || $past(wrMask));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    property p_ovr;
        overflow_reg && !clearAll |=> overflow_reg;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overflow flag dropped");

    property p_rxact;
        tagMsgStart || (rxActive_reg && !tagMsgEnd && !clearAll) |=> rxActive_reg;
    endproperty
    a_rxact: assert property (p_rxact) else $error("rx active dropped early");

    property p_clear;
        clearAll && !fifoPushWhenFull && !tagMsgStart && !(bitCollisionEvt && isoAMode)
            |=> fifoStatusView == 8'h00 && collisionView == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left status");

    // set priority, read port and unread count checks
    property p_ovrset;
        fifoPushWhenFull |=> overflow_reg;
    endproperty
    a_ovrset: assert property (p_ovrset) else $error("overflow flag not set");

    property p_rdset;
        rdFlags |=> eventFlags_reg == $past(eventSet);
    endproperty
    a_rdset: assert property (p_rdset) else $error("read lost an event");

    property p_setdef;
        setDefaultCmd |=> eventFlags_reg == $past(eventSet)
            && waterLevelMask_reg == reader_status_pkg::EVENT_MASK_RST;
    endproperty
    a_setdef: assert property (p_setdef) else $error("set-default missed");

    property p_count;
        !clearAll && fifoUnread <= reader_status_pkg::UNREAD_COUNT_MAX
            |=> unreadCount_reg == $past(fifoUnread);
    endproperty
    a_count: assert property (p_count) else $error("unread count not mirrored");

    property p_cntmax;
        unreadCount_reg <= reader_status_pkg::UNREAD_COUNT_MAX;
    endproperty
    a_cntmax: assert property (p_cntmax) else $error("unread count out of range");

    property p_rdhold;
        !regRdEn |=> $stable(regRdData);
    endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data changed without a read");

    c_rdclr: cover property (rdFlags && eventFlags_reg != 8'h00);
    c_ovr: cover property (fifoPushWhenFull ##1 clearCmd);
    c_col: cover property (bitCollisionEvt && isoAMode ##1 regRdEn);
    c_irq: cover property ($rose(irqOutPin) ##[1:20] $fell(irqOutPin));
endmodule
`default_nettype wire

// [test/reader_host_model.sv]
// host model driving the register port of the status register group
`timescale 1ns/100ps
`default_nettype none
module reader_host_model (
    input wire logic clk,
    output logic [reader_status_pkg::ADDR_W-1:0] regAddr,
    output logic regRdEn,
    output logic regWrEn,
    output logic [reader_status_pkg::DATA_W-1:0] regWrData,
    input wire logic [reader_status_pkg::DATA_W-1:0] regRdData
);
    // idle port at time zero
    initial begin
        regAddr = 6'h00;
        regRdEn = 1'h0;
        regWrEn = 1'h0;
        regWrData = 8'h00;
    end
    // one read strobe; registered data taken after the read edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        @(posedge clk);
        regRdEn <= 1'h0;
        #1;
        d = regRdData;
    endtask
    // one write strobe; no answer on this port
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge clk);
        regWrEn <= 1'h0;
        regWrData <= ~d; // released data does not keep its last value
    endtask
endmodule
`default_nettype wire

// [test/reader_irq_fifo_status_regs_tb.sv]
// self-checking bench for the status and event register group
`timescale 1ns/100ps
`default_nettype none
module reader_irq_fifo_status_regs_tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] lvl = 4'h0;
    logic [14:0] stim = 15'h0000;
    logic [3:0] clashByte = 4'hf;
    logic [2:0] clashBit = 3'h7;
    logic [5:0] fifoUnread = 6'h00;
    logic [7:0] d;
    int mismatches = 0;
    int n_checks = 0;
    wire [5:0] regAddr;
    wire [7:0] regWrData;
    wire [7:0] regRdData;
    wire regRdEn, regWrEn, irqOutPin, oscEnable, nfcTargetDetect, txBusy, isoAMode;
    wire oscStable, extFieldDetect, caFieldAbort, fifoAlmostFull, fifoAlmostEmpty;
    wire rxEndEvt, txEndEvt, codingErrEvt, crcErrEvt, bitCollisionEvt;
    wire fifoPushWhenFull, tagMsgStart, tagMsgEnd, setDefaultCmd, clearCmd;
    // event table: levels, pulses, expected flags
    localparam logic [3:0] LV [14] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h0,
        4'h4, 4'hc, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0};
    localparam logic [14:0] EV [14] = '{15'h0040, 15'h0080, 15'h0100, 15'h0200,
        15'h1000, 15'h4000, 15'h4000, 15'h2000, 15'h2000, 15'h0800, 15'h0400,
        15'h0400, 15'h0020, 15'h0020};
    localparam logic [7:0] EX [14] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80,
        8'h00, 8'h40, 8'h00, 8'h20, 8'h20, 8'h00, 8'h01, 8'h00};
    assign {oscEnable, nfcTargetDetect, txBusy, isoAMode} = lvl;
    assign {oscStable, extFieldDetect, caFieldAbort, fifoAlmostFull, fifoAlmostEmpty,
        rxEndEvt, txEndEvt, codingErrEvt, crcErrEvt, bitCollisionEvt, fifoPushWhenFull,
        tagMsgStart, tagMsgEnd, setDefaultCmd, clearCmd} = stim;
    // clock, 10 ns period
    always #5 clk = ~clk;
    reader_host_model i_reader_host_model (
        .clk(clk), .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdData(regRdData)
    );
    reader_irq_fifo_status_regs i_reader_irq_fifo_status_regs (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regRdEn(regRdEn),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
        .setDefaultCmd(setDefaultCmd), .clearCmd(clearCmd), .oscEnable(oscEnable),
        .oscStable(oscStable), .nfcTargetDetect(nfcTargetDetect),
        .extFieldDetect(extFieldDetect), .caFieldAbort(caFieldAbort),
        .fifoAlmostFull(fifoAlmostFull), .fifoAlmostEmpty(fifoAlmostEmpty),
        .txBusy(txBusy), .rxEndEvt(rxEndEvt), .txEndEvt(txEndEvt),
        .codingErrEvt(codingErrEvt), .crcErrEvt(crcErrEvt),
        .bitCollisionEvt(bitCollisionEvt), .isoAMode(isoAMode),
        .clashByteCount(clashByte), .clashBitCount(clashBit), .fifoUnread(fifoUnread),
        .fifoPushWhenFull(fifoPushWhenFull), .tagMsgStart(tagMsgStart),
        .tagMsgEnd(tagMsgEnd), .irqOutPin(irqOutPin)
    );
    // compare one value and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // read a register and compare
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        i_reader_host_model.rd(a, d);
        chk("register read", d, exp);
    endtask
    // levels and a one-cycle pulse set on one edge
    task automatic fire(input logic [3:0] l, input logic [14:0] ev);
        @(posedge clk);
        lvl <= l;
        stim <= ev;
        @(posedge clk);
        stim <= 15'h0000;
        #1;
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        chk("irq after reset", {7'h00, irqOutPin}, 8'h00);
        rdc(6'h07, 8'h00);
        rdc(6'h08, 8'h00);
        rdc(6'h09, 8'h00);
        rdc(6'h0a, 8'h00);
        rdc(6'h3f, 8'h00);
        $display("test reset done");
        fire(4'h0, 15'h0008); // reception active for the water level entry
        for (int i = 0; i < 14; i++) begin
            fire(LV[i], EV[i]);
            chk("irq on event", {7'h00, irqOutPin}, {7'h00, EX[i] != 8'h00});
            rdc(6'h08, EX[i]);
            rdc(6'h08, 8'h00);
            chk("irq after read", {7'h00, irqOutPin}, 8'h00);
        end
        rdc(6'h0a, 8'hfe);
        // read of the flags in the same cycle as a new event
        fire(4'h0, 15'h0100);
        fork
            rdc(6'h08, 8'h08);
            fire(4'h0, 15'h0040);
        join
        chk("irq after read race", {7'h00, irqOutPin}, 8'h01);
        rdc(6'h08, 8'h02);
        $display("test events done");
        i_reader_host_model.wr(6'h07, 8'h02);
        rdc(6'h07, 8'h02);
        fire(4'h0, 15'h0040);
        chk("masked irq", {7'h00, irqOutPin}, 8'h00);
        fire(4'h0, 15'h0080);
        chk("unmasked irq", {7'h00, irqOutPin}, 8'h01);
        rdc(6'h08, 8'h06);
        $display("test mask done");
        fifoUnread <= 6'h3f;
        rdc(6'h09, 8'h81);
        fire(4'h0, 15'h0010);
        rdc(6'h09, 8'h83);
        fifoUnread <= 6'h15;
        i_reader_host_model.wr(6'h09, 8'hff);
        rdc(6'h09, 8'h57);
        fire(4'h0, 15'h0004);
        rdc(6'h09, 8'h56);
        fifoUnread <= 6'h00;
        fire(4'h0, 15'h0001);
        rdc(6'h09, 8'h00);
        rdc(6'h0a, 8'h00);
        rdc(6'h07, 8'h02);
        $display("test fifo done");
        clashByte <= 4'h5;
        clashBit <= 3'h3;
        fire(4'h1, 15'h0028);
        rdc(6'h0a, 8'h56);
        fire(4'h1, 15'h0040);
        fire(4'h0, 15'h0002);
        rdc(6'h08, 8'h00);
        rdc(6'h07, 8'h00);
        rdc(6'h09, 8'h00);
        rdc(6'h0a, 8'h00);
        fire(4'h0, 15'h0042);
        rdc(6'h08, 8'h02);
        $display("test set default done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
